// file: timer_freeze_control.sv
// Timer freeze register bank: software and debug holds for the timing agents
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module timer_freeze_control (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [31:0]                   hwdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  // Core and watchdog state
  input  wire logic                          cpu_debug_halted,
  input  wire logic                          watchdog_nmi_select,
  // Agent holds
  output logic                               hold_dma,
  output logic                               hold_watchdog,
  output logic                               hold_link_master_clock,
  output logic                               hold_software_timer,
  output logic                               hold_wakeup_timer,
  // Status
  output logic                               calibration_pending
);
  import timer_freeze_pkg::*;

  // Bus side
  logic                    wr_en;
  logic                    rd_en;
  logic [INDEX_W-1:0]      reg_index;
  logic [REG_W-1:0]        wr_data;
  logic [REG_W-1:0]        rd_data;

  // Register contents
  logic [REG_W-1:0]        debug_ctrl_r;
  logic [REG_W-1:0]        debug_ctrl_nxt;
  logic [STATUS_W-1:0]     status_r;
  logic [STATUS_W-1:0]     status_nxt;
  logic [HOLD_COUNT-1:0]   hold_state;
  logic [HOLD_COUNT-1:0]   hold_out;

  // Address decode
  wire                     sel_set     = (reg_index == FREEZE_SET_INDEX);
  wire                     sel_release = (reg_index == FREEZE_RELEASE_INDEX);
  wire                     sel_debug   = (reg_index == DEBUG_CTRL_INDEX);
  wire                     sel_status  = (reg_index == STATUS_FLAGS_INDEX);
  wire                     wr_set      = wr_en && sel_set;
  wire                     wr_release  = wr_en && sel_release;
  wire                     wr_debug    = wr_en && sel_debug;
  wire                     wr_status   = wr_en && sel_status;
  wire                     debug_en    = debug_ctrl_r[DEBUG_HOLD_EN_BIT];
  wire [HOLD_COUNT-1:0]    set_req     = wr_set ? wr_data[HOLD_COUNT-1:0] : '0;
  wire [HOLD_COUNT-1:0]    release_req = wr_release ? wr_data[HOLD_COUNT-1:0] : '0;
  wire [HOLD_COUNT-1:0]    allowed;
  wire [REG_W-1:0]         hold_word   = {{(REG_W-HOLD_COUNT){1'b0}}, hold_state};
  wire [REG_W-1:0]         status_word = {{(REG_W-STATUS_W){1'b0}}, status_r};

  // Only the watchdog has a condition on its software hold
  assign allowed = {{(HOLD_COUNT-HOLD_WATCHDOG_BIT-1){1'b1}}, ~watchdog_nmi_select,
                    {HOLD_WATCHDOG_BIT{1'b1}}};

  freeze_ahb_slave u_bus (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .reg_index (reg_index),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  // One hold cell per agent; bit i of both freeze registers drives cell i
  genvar gi;
  generate
    for (gi = 0; gi < HOLD_COUNT; gi++) begin : g_hold
      freeze_hold_cell #(
        .WATCHDOG (gi == HOLD_WATCHDOG_BIT)
      ) u_cell (
        .mclk           (mclk),
        .arst_n         (arst_n),
        .set_req        (set_req[gi]),
        .release_req    (release_req[gi]),
        .freeze_allowed (allowed[gi]),
        .debug_halted   (cpu_debug_halted),
        .debug_hold_en  (debug_en),
        .hold_state     (hold_state[gi]),
        .hold_out       (hold_out[gi])
      );
    end
  endgenerate

  assign hold_dma               = hold_out[HOLD_DMA_BIT];
  assign hold_watchdog          = hold_out[HOLD_WATCHDOG_BIT];
  assign hold_link_master_clock = hold_out[HOLD_LINK_CLOCK_BIT];
  assign hold_software_timer    = hold_out[HOLD_SW_TIMER_BIT];
  assign hold_wakeup_timer      = hold_out[HOLD_WAKEUP_BIT];
  assign calibration_pending    = status_r[CAL_PENDING_BIT];

  // Unmapped addresses read zero; writes to them are dropped
  assign rd_data = (sel_set || sel_release) ? hold_word :
                   sel_debug  ? debug_ctrl_r :
                   sel_status ? status_word : '0;

  assign debug_ctrl_nxt = wr_debug ? wr_data : debug_ctrl_r;
  assign status_nxt     = wr_status ? wr_data[STATUS_W-1:0] : status_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      debug_ctrl_r <= DEBUG_CTRL_RESET;
      status_r     <= STATUS_FLAGS_RESET;
    end else begin
      debug_ctrl_r <= debug_ctrl_nxt;
      status_r     <= status_nxt;
    end
  end

  // Checks on the hold logic, the register bank and the bus timing
  logic first_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_set_halts: assert property (
    wr_set |=> ((hold_state & $past(wr_data[HOLD_COUNT-1:0])) == $past(wr_data[HOLD_COUNT-1:0]))
               && ((hold_state & ~$past(wr_data[HOLD_COUNT-1:0]))
                   == ($past(hold_state) & ~$past(wr_data[HOLD_COUNT-1:0]))))
    else $error("freeze set did not set exactly the written bits");

  a_release_runs: assert property (
    wr_release |=> ((hold_state & $past(wr_data[HOLD_COUNT-1:0])) == '0)
                   && ((hold_state | $past(wr_data[HOLD_COUNT-1:0]))
                       == ($past(hold_state) | $past(wr_data[HOLD_COUNT-1:0]))))
    else $error("freeze release did not clear exactly the written bits");

  a_dma_bit_map: assert property (
    (wr_set && wr_data[HOLD_DMA_BIT] && !cpu_debug_halted) ##1 !cpu_debug_halted
      |=> hold_dma)
    else $error("dma hold not raised by bit 4 of freeze set");

  a_reset_values: assert property (
    first_r |-> (hold_state == HOLD_RESET) && (hold_out == HOLD_RESET)
                && (debug_ctrl_r == DEBUG_CTRL_RESET) && (status_r == STATUS_FLAGS_RESET))
    else $error("register bank not at reset values after reset");

  a_swtimer_bit_map: assert property (
    (wr_release && wr_data[HOLD_SW_TIMER_BIT] && !cpu_debug_halted) ##1 !cpu_debug_halted
      |=> !hold_software_timer)
    else $error("software timer hold not released by bit 1");

  a_wdog_nmi_gate: assert property (
    (watchdog_nmi_select && !cpu_debug_halted) |=> !hold_watchdog)
    else $error("watchdog held while its NMI select is one");

  a_wdog_soft_hold: assert property (
    (hold_state[HOLD_WATCHDOG_BIT] && !watchdog_nmi_select) |=> hold_watchdog)
    else $error("watchdog software hold not honoured");

  a_debug_all_hold: assert property (
    (cpu_debug_halted && debug_en) |=> (hold_out == {HOLD_COUNT{1'b1}}))
    else $error("debug halt with enable did not hold every agent");

  a_debug_soft_only: assert property (
    (cpu_debug_halted && !debug_en) |=> (hold_dma == $past(hold_state[HOLD_DMA_BIT]))
      && (hold_wakeup_timer == $past(hold_state[HOLD_WAKEUP_BIT])))
    else $error("debug halt without enable overrode software hold");

  a_wdog_debug: assert property (
    cpu_debug_halted |=> hold_watchdog)
    else $error("watchdog ran during debug halt");

  a_cal_flag: assert property (
    wr_status |=> (calibration_pending == $past(wr_data[CAL_PENDING_BIT])))
    else $error("calibration flag did not take the written value");

  a_readback_state: assert property (
    (rd_en && (sel_set || sel_release))
      |=> (hrdata == {16'h0000, {(REG_W-HOLD_COUNT){1'b0}}, $past(hold_state)}) ##0 hreadyout)
    else $error("freeze register read did not return the hold state");

  a_read_one_wait: assert property (
    (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not finish with exactly one wait state");

  // Hold state rebuilt from the bus pins alone, so a slave decode fault cannot hide itself
  logic                  ref_wr_r;
  logic [INDEX_W-1:0]    ref_index_r;
  logic [HOLD_COUNT-1:0] ref_hold_r;
  wire                   ref_accept  = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire                   ref_set     = ref_wr_r && (ref_index_r == FREEZE_SET_INDEX);
  wire                   ref_release = ref_wr_r && (ref_index_r == FREEZE_RELEASE_INDEX);
  wire [HOLD_COUNT-1:0]  ref_bits    = hwdata[HOLD_COUNT-1:0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_wr_r    <= 1'b0;
      ref_index_r <= '0;
      ref_hold_r  <= HOLD_RESET;
    end else begin
      ref_wr_r <= ref_accept && hwrite;
      if (ref_accept) begin
        ref_index_r <= haddr[INDEX_W+1:2];
      end
      if (ref_set) begin
        ref_hold_r <= ref_hold_r | ref_bits;
      end else if (ref_release) begin
        ref_hold_r <= ref_hold_r & ~ref_bits;
      end
    end
  end

  a_ref_state_match: assert property (
    hold_state == ref_hold_r)
    else $error("hold state differs from the bus reference");

  a_set_exact_ref: assert property (
    ref_set |=> (hold_state == ($past(ref_hold_r) | $past(ref_bits))))
    else $error("freeze set changed bits other than the ones written");

  a_set_all_hold: assert property (
    (wr_set && (wr_data[HOLD_COUNT-1:0] == {HOLD_COUNT{1'b1}})) |=> (hold_state == {HOLD_COUNT{1'b1}}))
    else $error("freeze set of all bits did not hold every agent");

  a_release_exact_ref: assert property (
    ref_release |=> (hold_state == ($past(ref_hold_r) & ~$past(ref_bits))))
    else $error("freeze release changed bits other than the ones written");

  a_release_all_run: assert property (
    (wr_release && (wr_data[HOLD_COUNT-1:0] == {HOLD_COUNT{1'b1}})) |=> (hold_state == '0))
    else $error("freeze release of all bits left an agent held");

  a_unused_bits: assert property (
    ((wr_set || wr_release) && (wr_data[HOLD_COUNT-1:0] == '0)) |=> $stable(hold_state))
    else $error("a write of zeros or unused bits changed a hold");

  a_link_bit_map: assert property (
    (wr_set && wr_data[HOLD_LINK_CLOCK_BIT]) |=> hold_state[HOLD_LINK_CLOCK_BIT])
    else $error("link clock hold not set by bit 2");

  a_wdog_bit_map: assert property (
    (wr_set && wr_data[HOLD_WATCHDOG_BIT]) |=> hold_state[HOLD_WATCHDOG_BIT])
    else $error("watchdog hold not set by bit 3");

  a_dma_release_map: assert property (
    (wr_release && wr_data[HOLD_DMA_BIT]) |=> !hold_state[HOLD_DMA_BIT])
    else $error("dma hold not released by bit 4");

  a_swtimer_set_map: assert property (
    (wr_set && wr_data[HOLD_SW_TIMER_BIT]) |=> hold_state[HOLD_SW_TIMER_BIT])
    else $error("software timer hold not set by bit 1");

  a_wakeup_bit_map: assert property (
    (wr_release && wr_data[HOLD_WAKEUP_BIT]) |=> !hold_state[HOLD_WAKEUP_BIT])
    else $error("wake-up timer hold not released by bit 0");

  a_quiet_no_hold: assert property (
    (!cpu_debug_halted && (ref_hold_r == '0)) |=> (hold_out == '0))
    else $error("an agent held with no hold requested");

  a_plain_hold_out: assert property (
    1'b1 |=> ({hold_dma, hold_link_master_clock, hold_software_timer, hold_wakeup_timer}
              == ($past({ref_hold_r[HOLD_DMA_BIT], ref_hold_r[HOLD_LINK_CLOCK_BIT], ref_hold_r[HOLD_SW_TIMER_BIT],
                         ref_hold_r[HOLD_WAKEUP_BIT]}) | {4{$past(cpu_debug_halted && debug_en)}})))
    else $error("timer hold output does not follow hold state and debug halt");

  a_wdog_hold_out: assert property (
    1'b1 |=> (hold_watchdog == $past((ref_hold_r[HOLD_WATCHDOG_BIT] && !watchdog_nmi_select) || cpu_debug_halted)))
    else $error("watchdog hold output does not follow its conditions");

  a_soft_hold_kept: assert property (
    (hold_state[HOLD_SW_TIMER_BIT] && cpu_debug_halted && !debug_en) |=> hold_software_timer)
    else $error("software hold dropped during debug halt");

  a_long_halt_wdog: assert property (
    cpu_debug_halted [*4] |=> hold_watchdog)
    else $error("watchdog ran during a long debug halt");

  a_debug_ctrl_write: assert property (
    wr_debug |=> (debug_ctrl_r == $past(wr_data)))
    else $error("debug control did not take the written value");

  a_debug_ctrl_keep: assert property (
    !wr_debug |=> $stable(debug_ctrl_r))
    else $error("debug control changed without a write");

  a_status_keep: assert property (
    !wr_status |=> $stable(status_r))
    else $error("status flags changed without a write");

  a_readback_debug: assert property (
    (rd_en && sel_debug) |=> (hrdata == {16'h0000, $past(debug_ctrl_r)}))
    else $error("debug control read returned a wrong value");

  a_readback_status: assert property (
    (rd_en && sel_status) |=> (hrdata == {16'h0000, {(REG_W-STATUS_W){1'b0}}, $past(status_r)}))
    else $error("status read returned a wrong value");

  a_readback_unmapped: assert property (
    (rd_en && !(sel_set || sel_release || sel_debug || sel_status)) |=> (hrdata == 32'h0000_0000))
    else $error("unmapped read did not return zero");

  a_hrdata_hold: assert property (
    !rd_en |=> $stable(hrdata))
    else $error("read data changed outside a read");

  a_write_no_wait: assert property (
    (ref_accept && hwrite) |=> hreadyout)
    else $error("write inserted a wait state");

endmodule

// file: timer_freeze_pkg.sv
// Constants, register map and bus states for the timer freeze register bank
package timer_freeze_pkg;

  // Printed register offsets; the low 16 bits of each are also the register's word index
  localparam logic [31:0] FREEZE_SET_OFFSET     = 32'h5000_3300;
  localparam logic [31:0] FREEZE_RELEASE_OFFSET = 32'h5000_3302;
  localparam logic [31:0] DEBUG_CTRL_OFFSET     = 32'h5000_3304;
  localparam logic [31:0] STATUS_FLAGS_OFFSET   = 32'h5000_3306;

  // Decoded index width: haddr[17:2] is compared with the low index bits
  localparam int          INDEX_W               = 16;
  localparam logic [15:0] FREEZE_SET_INDEX      = FREEZE_SET_OFFSET[15:0];
  localparam logic [15:0] FREEZE_RELEASE_INDEX  = FREEZE_RELEASE_OFFSET[15:0];
  localparam logic [15:0] DEBUG_CTRL_INDEX      = DEBUG_CTRL_OFFSET[15:0];
  localparam logic [15:0] STATUS_FLAGS_INDEX    = STATUS_FLAGS_OFFSET[15:0];

  // Hold field positions, shared by the set and release registers
  localparam int          HOLD_COUNT            = 5;
  localparam int          HOLD_DMA_BIT          = 4;
  localparam int          HOLD_WATCHDOG_BIT     = 3;
  localparam int          HOLD_LINK_CLOCK_BIT   = 2;
  localparam int          HOLD_SW_TIMER_BIT     = 1;
  localparam int          HOLD_WAKEUP_BIT       = 0;

  // Other field positions and widths
  localparam int          DEBUG_HOLD_EN_BIT     = 0;
  localparam int          CAL_PENDING_BIT       = 0;
  localparam int          STATUS_W              = 2;
  localparam int          REG_W                 = 16;

  // Values after reset
  localparam logic [4:0]  HOLD_RESET            = 5'h00;
  localparam logic [15:0] DEBUG_CTRL_RESET      = 16'h0001;
  localparam logic [1:0]  STATUS_FLAGS_RESET    = 2'h0;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ         = 2'h2;
  localparam logic        HRESP_OKAY            = 1'h0;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_e;

endpackage

// file: freeze_ahb_slave.sv
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/100ps
module freeze_ahb_slave (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                arst_n,
  // AHB-Lite
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic                                hready,
  input  wire logic [31:0]                         hwdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  output logic      [31:0]                         hrdata,
  // Register side
  output logic                                     wr_en,
  output logic                                     rd_en,
  output logic      [timer_freeze_pkg::INDEX_W-1:0] reg_index,
  output logic      [timer_freeze_pkg::REG_W-1:0]   wr_data,
  input  wire logic [timer_freeze_pkg::REG_W-1:0]   rd_data
);
  import timer_freeze_pkg::*;

  bus_state_e            state_r;
  bus_state_e            state_nxt;
  logic [INDEX_W-1:0]    index_r;
  wire                   accept   = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Read data is sampled one cycle late so that a write just ahead is seen
  assign hreadyout = (state_r != BUS_READ_WAIT);
  assign hresp     = HRESP_OKAY;
  assign wr_en     = (state_r == BUS_WRITE);
  assign rd_en     = (state_r == BUS_READ_WAIT);
  assign reg_index = index_r;
  assign wr_data   = hwdata[REG_W-1:0];

  always_comb begin
    state_nxt = BUS_IDLE;
    case (state_r)
      BUS_READ_WAIT: state_nxt = BUS_READ_DONE;
      default: begin
        if (accept) begin
          state_nxt = hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= BUS_IDLE;
      index_r <= '0;
      hrdata  <= '0;
    end else begin
      state_r <= state_nxt;
      if (accept) begin
        index_r <= haddr[INDEX_W+1:2];
      end
      if (rd_en) begin
        hrdata <= {16'h0000, rd_data};
      end
    end
  end

endmodule

// file: freeze_hold_cell.sv
// One agent's hold state and its registered hold output
`timescale 1ns/100ps
module freeze_hold_cell #(
  parameter bit WATCHDOG = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Software requests
  input  wire logic set_req,
  input  wire logic release_req,
  // Hold conditions
  input  wire logic freeze_allowed,
  input  wire logic debug_halted,
  input  wire logic debug_hold_en,
  // State and hold
  output logic      hold_state,
  output logic      hold_out
);
  logic hold_state_nxt;
  logic hold_out_nxt;

  // A zero written to either register leaves the state alone
  assign hold_state_nxt = set_req ? 1'b1 : (release_req ? 1'b0 : hold_state);

  // The watchdog ignores software holds while its NMI select is one, yet always stops under debug
  generate
    if (WATCHDOG) begin : g_wdog
      assign hold_out_nxt = (hold_state & freeze_allowed) | debug_halted;
    end else begin : g_plain
      assign hold_out_nxt = hold_state | (debug_halted & debug_hold_en);
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_state <= 1'b0;
      hold_out   <= 1'b0;
    end else begin
      hold_state <= hold_state_nxt;
      hold_out   <= hold_out_nxt;
    end
  end

endmodule

// file: timer_freeze_control_bench.sv
// Self-checking bench for the timer freeze register bank
`timescale 1ns/100ps
module timer_freeze_control_bench;
  import timer_freeze_pkg::*;
  localparam logic [31:0] A_SET = 32'h0000_CC00;
  localparam logic [31:0] A_REL = 32'h0000_CC08;
  localparam logic [31:0] A_DBG = 32'h0000_CC10;
  localparam logic [31:0] A_STA = 32'h0000_CC18;
  localparam logic [31:0] A_BAD = 32'h0000_CC20;
  logic        mclk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        cpu_debug_halted, watchdog_nmi_select, calibration_pending;
  logic        h_dma, h_wd, h_link, h_sw, h_wk;
  logic [4:0]  st;
  logic [15:0] dbg;
  logic [1:0]  stat;
  logic        halt, nmi;
  int          mismatches, n_compared;

  timer_freeze_control DUT (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_debug_halted(cpu_debug_halted), .watchdog_nmi_select(watchdog_nmi_select),
    .hold_dma(h_dma), .hold_watchdog(h_wd), .hold_link_master_clock(h_link),
    .hold_software_timer(h_sw), .hold_wakeup_timer(h_wk), .calibration_pending(calibration_pending)
  );

  always #5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for the slave; a stuck bus ends the run as a failure
  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
      if (t > 100) begin
        mismatches++;
        $display("ERROR hreadyout expected 1 seen stuck low");
        close_out();
      end
    end while (hreadyout !== 1'b1);
  endtask

  // One single word transfer; waits on the slave, never on a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : {$urandom};
    wait_ready();
    q = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  // Upper data half carries noise: only the low 16 bits are register bits
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'($urandom), d}, q);
    case (a)
      A_SET: st = st | d[4:0];
      A_REL: st = st & ~d[4:0];
      A_DBG: dbg = d;
      A_STA: stat = d[1:0];
      default: ;
    endcase
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask

  function automatic logic [4:0] exp_hold();
    logic [4:0] h;
    h = st | {5{halt & dbg[DEBUG_HOLD_EN_BIT]}};
    h[HOLD_WATCHDOG_BIT] = (st[HOLD_WATCHDOG_BIT] & ~nmi) | halt;
    return h;
  endfunction

  // Holds lag state and inputs by one registered stage, so let two edges pass
  task automatic hold_chk();
    repeat (2) @(posedge mclk);
    #1;
    chk("holds", {27'h0, exp_hold()}, {27'h0, h_dma, h_wd, h_link, h_sw, h_wk});
    chk("calibration_pending", {31'h0, stat[0]}, {31'h0, calibration_pending});
  endtask

  task automatic drive(input logic hl, input logic nm);
    @(posedge mclk);
    cpu_debug_halted <= hl;
    watchdog_nmi_select <= nm;
    halt = hl;
    nmi = nm;
  endtask

  task automatic close_out();
    $display("Compared %0d values, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("ERROR watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    logic [15:0] v;
    int          k;
    mclk = 1'b0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    cpu_debug_halted = 1'b0;
    watchdog_nmi_select = 1'b0;
    st = HOLD_RESET;
    dbg = DEBUG_CTRL_RESET;
    stat = STATUS_FLAGS_RESET;
    halt = 1'b0;
    nmi = 1'b0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'hc6d2));
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rd_chk("freeze_set", A_SET, 32'h0000_0000);
    rd_chk("freeze_release", A_REL, 32'h0000_0000);
    rd_chk("debug_halt_control", A_DBG, 32'h0000_0001);
    rd_chk("system_status_flags", A_STA, 32'h0000_0000);
    hold_chk();
    drive(1'b1, 1'b1);
    hold_chk();
    $display("test reset_values done");
    wr(A_DBG, 16'h0000);
    hold_chk();
    drive(1'b0, 1'b1);
    wr(A_SET, 16'hFFFF);
    hold_chk();
    rd_chk("freeze_release", A_REL, 32'h0000_001F);
    drive(1'b0, 1'b0);
    hold_chk();
    wr(A_REL, 16'h0008);
    hold_chk();
    wr(A_REL, 16'h0000);
    hold_chk();
    $display("test watchdog_corners done");
    wr(A_STA, 16'hFFFF);
    rd_chk("system_status_flags", A_STA, 32'h0000_0003);
    hold_chk();
    wr(A_STA, 16'h0002);
    hold_chk();
    wr(A_BAD, 16'hFFFF);
    rd_chk("unmapped", A_BAD, 32'h0000_0000);
    rd_chk("freeze_set", A_SET, {27'h0, st});
    $display("test status_and_unmapped done");
    for (int i = 0; i < 80; i++) begin
      k = $urandom_range(0, 4);
      v = 16'($urandom);
      case (k)
        0: wr(A_SET, v & 16'($urandom));
        1: wr(A_REL, v & 16'($urandom));
        2: wr(A_DBG, v);
        default: drive(v[0], v[1]);
      endcase
      hold_chk();
      if (i % 10 == 0) begin
        rd_chk("freeze_set", A_SET, {27'h0, st});
        rd_chk("freeze_release", A_REL, {27'h0, st});
        rd_chk("debug_halt_control", A_DBG, {16'h0000, dbg});
      end
    end
    $display("test random_mix done");
    close_out();
  end
endmodule
